/* File: core/sysopt_top.sv */
// write-once system options register on ahb-lite
// assumes hresetn is driven by every reset source, including the two
// reset requests that this block itself raises
// Contract
// [RULE1] only first write after reset is honored
// [RULE2] readable always, bits 4 to 2 zero
// [RULE3] software writes options once after reset
// [RULE4] watchdog enable resets one, enables timeout reset
// [RULE5] timeout select: zero 2^18, one 2^20
// [RULE6] stop permit resets zero, one allows stop
// [RULE7] stop without permit forces illegal-opcode reset
// [RULE8] debug enable selects debug pin role
// [RULE9] debug pin enable defaults set
// [RULE10] reset pin enable defaults set, selects role
// [RULE11] every reset restores lock and options
`timescale 1ns/100ps
module sysopt_top #(
   parameter logic [20:0] WDOG_SHORT = sysopt_pkg::WDOG_SHORT_CYCLES,
   parameter logic [20:0] WDOG_LONG = sysopt_pkg::WDOG_LONG_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic stop_request,
   input wire logic watchdog_service,
   input wire logic port_d_bit_zero_out,
   input wire logic port_d_bit_one_out,
   output logic stop_enter,
   output logic illegal_opcode_reset,
   output logic watchdog_reset,
   output logic debug_pin_enable,
   output logic reset_pin_enable,
   output logic port_d_bit_zero_oe,
   output logic port_d_bit_one_oe
);
   ////////////////////////////////////////////////////////////////////
   logic [7:0] opt_reg;
   logic [7:0] opt_next;
   logic locked_reg;
   logic locked_next;
   logic wr_pend_reg;
   logic wr_pend_next;
   logic [11:0] addr_reg;
   logic [11:0] addr_next;
   sysopt_pkg::sysopt_phase_t phase_reg;
   sysopt_pkg::sysopt_phase_t phase_next;
   logic [31:0] rdata_next;
   logic stop_sync1_reg;
   logic stop_sync2_reg;
   logic stop_enter_next;
   logic illegal_next;
   logic wdog_timeout;
   logic take;
   logic watchdog_reset_next;
   logic debug_pin_next;
   logic reset_pin_next;
   logic port_zero_oe_next;
   logic port_one_oe_next;

   function automatic logic [31:0] read_word(input logic [11:0] a,
                                             input logic [7:0] o,
                                             input logic l);
      if (a == sysopt_pkg::SYSOPT_OFFSET) begin
         read_word = {24'h000000, o & sysopt_pkg::SYSOPT_IMPL_MASK}; // RULE2
      end else if (a == sysopt_pkg::SYSOPT_STATUS_OFFSET) begin
         read_word = {31'h00000000, l};
      end else begin
         read_word = 32'h00000000;
      end
   endfunction : read_word

   assign take = hsel && hready && htrans[1];

   ////////////////////////////////////////////////////////////////////
   // bus phase tracking and the write-once register
   always_comb begin
      phase_next = take ? sysopt_pkg::SYSOPT_DATA : sysopt_pkg::SYSOPT_IDLE;
      addr_next = take ? haddr[11:0] : addr_reg;
      wr_pend_next = take && hwrite;
      opt_next = opt_reg;
      locked_next = locked_reg;
      // later writes dropped to protect the settings
      if (wr_pend_reg && phase_reg == sysopt_pkg::SYSOPT_DATA
          && addr_reg == sysopt_pkg::SYSOPT_OFFSET
          && !locked_reg) begin // RULE1
         opt_next = hwdata[7:0] & sysopt_pkg::SYSOPT_IMPL_MASK; // RULE2
         locked_next = 1'b1; // RULE1
      end
      rdata_next = (take && !hwrite)
                   ? read_word(haddr[11:0], opt_next, locked_next)
                   : 32'h00000000;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opt_reg <= sysopt_pkg::SYSOPT_RESET; // RULE4 RULE5 RULE6 RULE9
         locked_reg <= 1'b0; // RULE11
         wr_pend_reg <= 1'b0;
         addr_reg <= 12'h000;
         phase_reg <= sysopt_pkg::SYSOPT_IDLE;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         opt_reg <= opt_next;
         locked_reg <= locked_next;
         wr_pend_reg <= wr_pend_next;
         addr_reg <= addr_next;
         phase_reg <= phase_next;
         hrdata <= rdata_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // stop request from the core: synchronised, then judged
   always_comb begin
      stop_enter_next = stop_sync2_reg
                        && opt_reg[sysopt_pkg::STOP_PERMIT_BIT]; // RULE6
      illegal_next = stop_sync2_reg
                     && !opt_reg[sysopt_pkg::STOP_PERMIT_BIT]; // RULE7
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_sync1_reg <= 1'b0;
         stop_sync2_reg <= 1'b0;
         stop_enter <= 1'b0;
         illegal_opcode_reset <= 1'b0;
      end else begin
         stop_sync1_reg <= stop_request;
         stop_sync2_reg <= stop_sync1_reg;
         stop_enter <= stop_enter_next;
         illegal_opcode_reset <= illegal_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // watchdog counter; its pulse feeds the system reset
   sysopt_wdog #(
      .SHORT_CYCLES(WDOG_SHORT),
      .LONG_CYCLES(WDOG_LONG)
   ) sysopt_wdog_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(opt_reg[sysopt_pkg::WDOG_EN_BIT]), // RULE4
      .long_sel(opt_reg[sysopt_pkg::WDOG_LONG_BIT]), // RULE5
      .service(watchdog_service),
      .timeout(wdog_timeout)
   );

   ////////////////////////////////////////////////////////////////////
   // pin role selection; port bits are output only when the role is off
   always_comb begin
      watchdog_reset_next = wdog_timeout; // RULE4
      debug_pin_next = opt_reg[sysopt_pkg::DEBUG_PIN_BIT]; // RULE8
      reset_pin_next = opt_reg[sysopt_pkg::RESET_PIN_BIT]; // RULE10
      port_zero_oe_next = !opt_reg[sysopt_pkg::DEBUG_PIN_BIT]; // RULE8
      port_one_oe_next = !opt_reg[sysopt_pkg::RESET_PIN_BIT]; // RULE10
   end

   // registered so every pin control comes straight from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         watchdog_reset <= 1'b0;
         debug_pin_enable <= 1'b1; // RULE9
         reset_pin_enable <= 1'b1; // RULE10
         port_d_bit_zero_oe <= 1'b0;
         port_d_bit_one_oe <= 1'b0;
      end else begin
         watchdog_reset <= watchdog_reset_next;
         debug_pin_enable <= debug_pin_next;
         reset_pin_enable <= reset_pin_next;
         port_d_bit_zero_oe <= port_zero_oe_next;
         port_d_bit_one_oe <= port_one_oe_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   AST_ONCE: assert property (@(posedge hclk) disable iff (!hresetn)
      locked_reg |=> $stable(opt_reg)) // RULE1
      else $error("locked options changed");
   AST_LOCK_SET: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && addr_reg == sysopt_pkg::SYSOPT_OFFSET)
      |=> locked_reg) // RULE1
      else $error("write did not lock");
   AST_ZERO_BITS: assert property (@(posedge hclk) disable iff (!hresetn)
      (opt_reg & ~sysopt_pkg::SYSOPT_IMPL_MASK) == 8'h00
      && hrdata[31:8] == 24'h000000
      && (hrdata[7:0] & ~sysopt_pkg::SYSOPT_IMPL_MASK) == 8'h00) // RULE2
      else $error("unimplemented bits nonzero");
   // three cycles: the pulse trails the enable by two flops
   AST_WDOG_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      !opt_reg[sysopt_pkg::WDOG_EN_BIT] [*3] |-> !watchdog_reset) // RULE4
      else $error("watchdog fired while disabled");
   AST_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_sync2_reg && opt_reg[sysopt_pkg::STOP_PERMIT_BIT]
      |=> stop_enter && !illegal_opcode_reset) // RULE6
      else $error("permitted stop not entered");
   AST_ILLEGAL: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_sync2_reg && !opt_reg[sysopt_pkg::STOP_PERMIT_BIT]
      |=> illegal_opcode_reset && !stop_enter) // RULE7
      else $error("forbidden stop did not reset");
   AST_DEBUG_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> debug_pin_enable == $past(opt_reg[sysopt_pkg::DEBUG_PIN_BIT])
      && port_d_bit_zero_oe == !debug_pin_enable) // RULE8
      else $error("debug pin role mismatch");
   AST_RESET_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> reset_pin_enable == $past(opt_reg[sysopt_pkg::RESET_PIN_BIT])
      && port_d_bit_one_oe == !reset_pin_enable) // RULE10
      else $error("reset pin role mismatch");
   AST_DEFAULTS: assert property (@(posedge hclk)
      !hresetn |=> (!locked_reg && opt_reg == sysopt_pkg::SYSOPT_RESET)
      || !hresetn) // RULE11
      else $error("lock survived reset");
   AST_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus not ready or error");
   CV_WRITE: cover property (@(posedge hclk) disable iff (!hresetn)
      !locked_reg ##1 locked_reg);
   CV_SECOND: cover property (@(posedge hclk) disable iff (!hresetn)
      locked_reg && wr_pend_reg);
   CV_ILLEGAL: cover property (@(posedge hclk) disable iff (!hresetn)
      illegal_opcode_reset);
   CV_STOP: cover property (@(posedge hclk) disable iff (!hresetn)
      stop_enter);
endmodule : sysopt_top

/* File: core/sysopt_pkg.sv */
// constants for the system options register block
// assumes a 32-bit ahb-lite bus at 25 mhz
package sysopt_pkg;
   localparam logic [11:0] SYSOPT_OFFSET = 12'h000;
   localparam logic [11:0] SYSOPT_STATUS_OFFSET = 12'h004;
   localparam int WDOG_EN_BIT = 7;
   localparam int WDOG_LONG_BIT = 6;
   localparam int STOP_PERMIT_BIT = 5;
   localparam int DEBUG_PIN_BIT = 1;
   localparam int RESET_PIN_BIT = 0;
   localparam logic [7:0] SYSOPT_RESET = 8'hc3;
   localparam logic [7:0] SYSOPT_IMPL_MASK = 8'he3;
   localparam int WDOG_SHORT_LOG2 = 18;
   localparam int WDOG_LONG_LOG2 = 20;
   localparam logic [20:0] WDOG_SHORT_CYCLES = 21'h040000;
   localparam logic [20:0] WDOG_LONG_CYCLES = 21'h100000;
   typedef enum logic [1:0] {
      SYSOPT_IDLE = 2'b01,
      SYSOPT_DATA = 2'b10
   } sysopt_phase_t;
endpackage : sysopt_pkg

/* File: core/sysopt_wdog.sv */
// watchdog counter steered by the option bits
// assumes one clock; the reset request is consumed by the system reset
`timescale 1ns/100ps
module sysopt_wdog #(
   parameter logic [20:0] SHORT_CYCLES = sysopt_pkg::WDOG_SHORT_CYCLES,
   parameter logic [20:0] LONG_CYCLES = sysopt_pkg::WDOG_LONG_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic enable,
   input wire logic long_sel,
   input wire logic service,
   output logic timeout
);
   logic [20:0] count_reg;
   logic [20:0] count_next;
   logic timeout_next;
   logic [20:0] limit;

   // count until the selected limit, pulse for one cycle, restart from zero
   always_comb begin
      limit = long_sel ? LONG_CYCLES : SHORT_CYCLES;
      count_next = count_reg;
      timeout_next = 1'b0;
      if (!enable || service) begin
         count_next = '0;
      end else if (count_reg == limit - 21'h000001) begin
         count_next = '0;
         timeout_next = 1'b1;
      end else begin
         count_next = count_reg + 21'h000001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_reg <= '0;
         timeout <= 1'b0;
      end else begin
         count_reg <= count_next;
         timeout <= timeout_next;
      end
   end
endmodule : sysopt_wdog

/* File: verif/tb_system_options_register.sv */
// self-checking bench for the write-once system options register
// assumes sysopt_top with hready looped back from hreadyout
`timescale 1ns/100ps
module tb_system_options_register;
   logic hclk, hresetn, hsel, hwrite, stop_request, watchdog_service;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, stop_enter, illegal_opcode_reset, watchdog_reset;
   logic debug_pin_enable, reset_pin_enable;
   logic port_d_bit_zero_oe, port_d_bit_one_oe;
   int n_mismatch = 0;
   int compares = 0;

   ////////////////////////////////////////////////////////////////////////
   // short watchdog counts keep the run brief
   sysopt_top #(.WDOG_SHORT(21'h000010), .WDOG_LONG(21'h000040))
      sysopt_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .stop_request(stop_request),
      .watchdog_service(watchdog_service), .port_d_bit_zero_out(1'b0),
      .port_d_bit_one_out(1'b0), .stop_enter(stop_enter),
      .illegal_opcode_reset(illegal_opcode_reset),
      .watchdog_reset(watchdog_reset), .debug_pin_enable(debug_pin_enable),
      .reset_pin_enable(reset_pin_enable),
      .port_d_bit_zero_oe(port_d_bit_zero_oe),
      .port_d_bit_one_oe(port_d_bit_one_oe));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t %s got %h", $time, m, got);
      end
   endtask : chk

   // one single ahb transfer; never assumes a wait-state count
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int i;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      i = 0;
      do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 99);
      r = hrdata;
      chk({31'h0, hresp}, 32'h0, "bad response");
      if (i >= 99) chk(32'h1, 32'h0, "bus hang");
   endtask : bus

   task automatic do_reset;
      hresetn <= 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
   endtask : do_reset

   task automatic t_defaults;
      bus(1'b0, 32'h0, 32'h0, q);
      chk(q, 32'h000000c3, "option defaults");
      chk({debug_pin_enable, reset_pin_enable, port_d_bit_one_oe,
           port_d_bit_zero_oe}, 32'hc, "pin roles at reset");
      bus(1'b0, 32'h4, 32'h0, q);
      chk(q, 32'h0, "lock clear at reset");
      bus(1'b0, 32'h8, 32'h0, q);
      chk(q, 32'h0, "unmapped read");
   endtask : t_defaults

   // first write sticks, reserved bits read zero, later write dropped
   task automatic t_write_once;
      bus(1'b1, 32'h0, 32'h0000003c, q);
      bus(1'b0, 32'h0, 32'h0, q);
      chk(q, 32'h00000020, "first write value");
      chk({debug_pin_enable, reset_pin_enable, port_d_bit_one_oe,
           port_d_bit_zero_oe}, 32'h3, "pins as port bits");
      bus(1'b1, 32'h0, 32'h000000c3, q);
      bus(1'b0, 32'h0, 32'h0, q);
      chk(q, 32'h00000020, "second write ignored");
      bus(1'b0, 32'h4, 32'h0, q);
      chk(q, 32'h1, "lock set");
   endtask : t_write_once

   // stop request: expect {stop_enter, illegal_opcode_reset}
   task automatic t_stop(input logic [1:0] exp);
      logic [1:0] seen;
      seen = 2'b00;
      stop_request <= 1'b1;
      repeat (8) begin
         @(posedge hclk);
         seen = seen | {stop_enter, illegal_opcode_reset};
      end
      stop_request <= 1'b0;
      chk({30'h0, seen}, {30'h0, exp}, "stop outcome");
      repeat (4) @(posedge hclk);
   endtask : t_stop

   // stop servicing and time the watchdog; limit 0 means none expected
   task automatic t_wdog(input int limit);
      int n;
      n = 0;
      watchdog_service <= 1'b0;
      do begin @(posedge hclk); n++; end
         while (watchdog_reset !== 1'b1 && n < 200);
      watchdog_service <= 1'b1;
      if (limit == 0) chk(n, 200, "watchdog fired while off");
      else chk({31'h0, n >= limit - 1 && n <= limit + 3}, 32'h1, "wdog time");
   endtask : t_wdog

   task automatic finish_test;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////
   // hang guard, well beyond the expected run length
   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end

   initial begin
      hresetn <= 1'b0;
      hsel <= 1'b0;
      haddr <= 32'h0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize <= 3'h2;
      hwdata <= 32'h0;
      stop_request <= 1'b0;
      watchdog_service <= 1'b1;
      do_reset();
      t_defaults();
      t_wdog(64);
      t_write_once();
      t_stop(2'b10);
      t_wdog(0);
      do_reset();
      t_defaults();
      t_stop(2'b01);
      do_reset();
      bus(1'b1, 32'h0, 32'h00000083, q);
      t_wdog(16);
      bus(1'b1, 32'h0, 32'h00000000, q);
      bus(1'b0, 32'h0, 32'h0, q);
      chk(q, 32'h00000083, "late write ignored");
      finish_test();
   end
endmodule : tb_system_options_register
